/* File: drive_control_one.sv */
`timescale 1ns/1ps
module drive_control_one
   import drive_ctl_pkg::*;
#(
   parameter int cnt_w = 20
) (
   // clock
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // actuator side
   input wire logic linear_resonant_actuator,
   input wire logic [cnt_w-1:0] period_trim,
   input wire logic trim_valid,
   output logic turn_on_kick,
   output logic input_bias_enable,
   output logic [cnt_w-1:0] drive_time_cyc,
   output logic bemf_sample
);
   // ----------------------------------------
   // parameter check
   // ----------------------------------------
   // the longest rotating-mass seed needs 19 bits; above 31 the int products overflow
   if (cnt_w < 19 || cnt_w > 31) begin : g_bad_width
      $error("cnt_w out of range");
   end

   typedef struct packed {
      logic kick;
      logic bias;
      logic [4:0] dtime;
      logic [cnt_w-1:0] drive;
      logic seeded;
      logic [7:0] rdata;
   } st_t;
   st_t s_q, s_d;
   logic [cnt_w-1:0] seed;
   logic sel_hit;
   logic tick;
   // ----------------------------------------
   // drive time seed
   // ----------------------------------------
   always_comb begin
      if (linear_resonant_actuator) begin
         seed = cnt_w'(s_q.dtime * lra_step_cyc + lra_base_cyc);
      end else begin
         seed = cnt_w'(s_q.dtime * erm_step_cyc + erm_base_cyc);
      end
   end
   assign sel_hit = reg_wr && reg_addr == ctl_one_addr;
   // ----------------------------------------
   // register and state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      if (sel_hit) begin
         s_d.kick = reg_wdata[kick_bit];
         s_d.bias = reg_wdata[bias_bit];
         s_d.dtime = reg_wdata[4:0];
      end
      // the first enabled edge after reset loads the seed in either mode
      if (sel_hit || !linear_resonant_actuator || !s_q.seeded) begin
         s_d.drive = seed;
         s_d.seeded = 1'b1;
      end else if (trim_valid) begin
         s_d.drive = period_trim;
      end
      if (sel_hit) begin
         s_d.drive = linear_resonant_actuator ? cnt_w'(reg_wdata[4:0] * lra_step_cyc
            + lra_base_cyc) : cnt_w'(reg_wdata[4:0] * erm_step_cyc + erm_base_cyc);
      end
      s_d.rdata = '0;
      if (reg_addr == ctl_one_addr) begin
         s_d.rdata = {s_d.kick, 1'b0, s_d.bias, s_d.dtime};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_q.kick <= ctl_one_reset[kick_bit];
         s_q.bias <= ctl_one_reset[bias_bit];
         s_q.dtime <= ctl_one_reset[4:0];
         s_q.drive <= '0;
         s_q.seeded <= 1'b0;
         s_q.rdata <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end
   // ----------------------------------------
   // back-EMF sample timer
   // ----------------------------------------
   drive_timer #(.cnt_w(cnt_w)) u_tmr (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .period_cyc(s_q.drive),
      .tick(tick)
   );
   assign bemf_sample = tick && !linear_resonant_actuator;
   assign turn_on_kick = s_q.kick;
   assign input_bias_enable = s_q.bias;
   assign drive_time_cyc = s_q.drive;
   assign reg_rdata = s_q.rdata;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_bias_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      sel_hit && clk_en |=> input_bias_enable == $past(reg_wdata[bias_bit]))
      else $error("bias bit not written");
   a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      reg_rdata[rsvd_bit] == 1'b0)
      else $error("reserved bit nonzero");
   a_lra_seed: assert property (@(posedge ref_clk) disable iff (!resetn)
      sel_hit && clk_en && linear_resonant_actuator |=>
      drive_time_cyc == cnt_w'($past(reg_wdata[4:0]) * lra_step_cyc + lra_base_cyc))
      else $error("resonant seed wrong");
   a_erm_time: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && !linear_resonant_actuator |=>
      drive_time_cyc == cnt_w'(s_q.dtime * erm_step_cyc + erm_base_cyc)
      || $past(sel_hit) || $past(linear_resonant_actuator))
      else $error("rotating drive time wrong");
   a_lra_trim: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && trim_valid && !sel_hit && linear_resonant_actuator && s_q.seeded |=>
      drive_time_cyc == $past(period_trim))
      else $error("trim not applied");
   a_bias_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
      $changed(input_bias_enable) |-> $past(sel_hit && clk_en) || !$past(resetn))
      else $error("bias moved without write");
   a_sample_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
      bemf_sample |-> !linear_resonant_actuator)
      else $error("sample in resonant mode");
   a_read_back: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && reg_addr == ctl_one_addr && !reg_wr |=>
      reg_rdata[4:0] == $past(s_q.dtime))
      else $error("read back wrong");

   // ----------------------------------------
   // shared sequences
   // ----------------------------------------
   // an accepted write to the control register
   sequence s_ctl_write;
      clk_en && sel_hit;
   endsequence

   // a seeded resonant cycle that neither writes nor trims
   sequence s_lra_hold;
      clk_en && !sel_hit && !trim_valid && linear_resonant_actuator && s_q.seeded;
   endsequence

   // an enabled write to some other address
   sequence s_foreign_write;
      clk_en && reg_wr && reg_addr != ctl_one_addr;
   endsequence

   // an enabled read of the control register
   sequence s_ctl_read;
      clk_en && !reg_wr && reg_addr == ctl_one_addr;
   endsequence

   // ----------------------------------------
   // further checks
   // ----------------------------------------
   // kick bit follows the written value
   a_kick_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ctl_write |=> turn_on_kick == $past(reg_wdata[kick_bit]))
      else $error("kick bit not written");

   // drive period field reads back what was written
   a_time_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ctl_write |=> reg_rdata[4:0] == $past(reg_wdata[4:0]))
      else $error("drive field not written");

   // resonant drive time holds between writes and trims
   a_lra_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_lra_hold |=> $stable(drive_time_cyc))
      else $error("resonant drive time moved");

   // writes elsewhere leave the fields alone
   a_foreign_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_foreign_write |=> $stable(turn_on_kick) && $stable(input_bias_enable))
      else $error("foreign write changed fields");

   // low clock enable freezes every output register
   a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      !clk_en |=> $stable(drive_time_cyc) && $stable(reg_rdata)
      && $stable(turn_on_kick) && $stable(input_bias_enable))
      else $error("state moved while frozen");

   // first seed after reset in resonant mode
   a_first_seed: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && !s_q.seeded && !sel_hit && linear_resonant_actuator |=>
      drive_time_cyc == cnt_w'($past(s_q.dtime) * lra_step_cyc + lra_base_cyc))
      else $error("first resonant seed wrong");

   // rotating-mass write takes effect at once
   a_erm_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ctl_write ##0 !linear_resonant_actuator |=>
      drive_time_cyc == cnt_w'($past(reg_wdata[4:0]) * erm_step_cyc + erm_base_cyc))
      else $error("rotating write time wrong");

   // sample strobe lasts one cycle
   a_sample_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      bemf_sample && clk_en && !sel_hit && !linear_resonant_actuator |=> !bemf_sample)
      else $error("sample strobe too long");

   // other addresses read as zero
   a_rdata_other: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && reg_addr != ctl_one_addr |=> reg_rdata == 8'h00)
      else $error("foreign read not zero");

   // read image carries the kick bit
   a_read_kick: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ctl_read |=> reg_rdata[kick_bit] == turn_on_kick)
      else $error("kick read back wrong");

   // read image carries the bias bit
   a_read_bias: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ctl_read |=> reg_rdata[bias_bit] == input_bias_enable)
      else $error("bias read back wrong");
endmodule

/* File: drive_ctl_pkg.sv */
// What this block does
// - With the input bias enable bit set, the block asks for 0.9 V common-mode drive on the input trigger pin.
// - The input bias enable bit reads 0 for no common-mode drive and 1 for drive, and resets to 0.
// - In resonant mode the first drive time after reset or a write in that mode is setting times 0.1 ms plus 0.5 ms.
// - In resonant mode that drive time is only a seed and is adjusted while running.
// - In rotating-mass mode the setting sets the back-EMF sampling period.
// - In rotating-mass mode the drive time is setting times 0.2 ms plus 1 ms.
package drive_ctl_pkg;
   localparam logic [7:0] ctl_one_addr = 8'h1B;
   localparam int kick_bit = 7;
   localparam int rsvd_bit = 6;
   localparam int bias_bit = 5;
   localparam logic [7:0] ctl_one_reset = 8'h93;
   localparam int clk_mhz = 50;
   // times in microseconds
   localparam int lra_step_us = 100;
   localparam int lra_base_us = 500;
   localparam int erm_step_us = 200;
   localparam int erm_base_us = 1000;
   localparam int lra_step_cyc = lra_step_us * clk_mhz;
   localparam int lra_base_cyc = lra_base_us * clk_mhz;
   localparam int erm_step_cyc = erm_step_us * clk_mhz;
   localparam int erm_base_cyc = erm_base_us * clk_mhz;
   localparam int bias_mv = 900;
endpackage

/* File: drive_timer.sv */
`timescale 1ns/1ps
// period timer: pulses tick once per period of period_cyc cycles
module drive_timer
   import drive_ctl_pkg::*;
#(
   parameter int cnt_w = 20
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [cnt_w-1:0] period_cyc,
   output logic tick
);
   typedef struct packed {
      logic [cnt_w-1:0] cnt;
      logic tick;
   } tmr_t;
   tmr_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt + 1'b1 >= period_cyc) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = cnt_w'(s_q.cnt + 1'b1);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end
   assign tick = s_q.tick;
endmodule

/* File: drive_control_one_test.sv */
`timescale 1ns/1ps
module drive_control_one_test;
   import drive_ctl_pkg::*;
   logic ref_clk, resetn, clk_en, reg_wr, resonant, trim_valid;
   logic turn_on_kick, input_bias_enable, bemf_sample;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [19:0] period_trim, drive_time_cyc;
   int n_errors = 0, checks = 0, cyc = 0;
   drive_control_one #(.cnt_w(20)) DUT (.ref_clk, .resetn, .clk_en, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rdata, .linear_resonant_actuator(resonant), .period_trim, .trim_valid,
      .turn_on_kick, .input_bias_enable, .drive_time_cyc, .bemf_sample);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task report_and_stop();
      if (n_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task chk(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_addr <= 8'h1B;
      #1;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset();
      chk(reg_rdata, 8'h93);
      chk(turn_on_kick, 1'b1);
      chk(input_bias_enable, 1'b0);
      chk(drive_time_cyc, 20'(19 * lra_step_cyc + lra_base_cyc));
   endtask
   task t_write();
      wr(8'h1B, 8'h7F);
      chk(reg_rdata, 8'h3F);
      chk(input_bias_enable, 1'b1);
      chk(drive_time_cyc, 20'(31 * lra_step_cyc + lra_base_cyc));
      wr(8'h1B, 8'h97);
      chk(reg_rdata, 8'h97);
      chk(turn_on_kick, 1'b1);
      chk(drive_time_cyc, 20'(23 * lra_step_cyc + lra_base_cyc));
      wr(8'h1B, 8'h00);
      chk(input_bias_enable, 1'b0);
      chk(turn_on_kick, 1'b0);
      chk(drive_time_cyc, 20'(lra_base_cyc));
      wr(8'h1C, 8'hFF);
      chk(reg_rdata, 8'h00);
      @(posedge ref_clk);
      #1;
      chk(reg_rdata, 8'h00);
      chk(input_bias_enable, 1'b0);
   endtask
   task t_freeze_trim();
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(8'h1B, 8'hFF);
      clk_en <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk(reg_rdata, 8'h00);
      @(posedge ref_clk);
      period_trim <= 20'h12345;
      trim_valid <= 1'b1;
      @(posedge ref_clk);
      trim_valid <= 1'b0;
      #1;
      chk(drive_time_cyc, 20'h12345);
      chk(bemf_sample, 1'b0);
   endtask
   task t_rotating();
      int n;
      @(posedge ref_clk);
      resonant <= 1'b0;
      wr(8'h1B, 8'h1F);
      chk(drive_time_cyc, 20'(31 * erm_step_cyc + erm_base_cyc));
      wr(8'h1B, 8'h00);
      chk(drive_time_cyc, 20'(erm_base_cyc));
      @(posedge ref_clk);
      period_trim <= 20'h00777;
      trim_valid <= 1'b1;
      @(posedge ref_clk);
      trim_valid <= 1'b0;
      #1;
      chk(drive_time_cyc, 20'(erm_base_cyc));
      // mid-run reset, then a write at the first edge after release
      @(posedge ref_clk);
      resetn <= 1'b0;
      @(posedge ref_clk);
      resetn <= 1'b1;
      reg_wr <= 1'b1;
      reg_wdata <= 8'h00;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
      chk(bemf_sample, 1'b1);
      chk(reg_rdata, 8'h00);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (bemf_sample !== 1'b1 && n < 60000);
      chk(20'(n), 20'(erm_base_cyc));
   endtask
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 8'h1B;
      reg_wdata = 8'h00;
      resonant = 1'b1;
      trim_valid = 1'b0;
      period_trim = 20'h00000;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      t_reset();
      t_write();
      t_freeze_trim();
      t_rotating();
      report_and_stop();
   end
endmodule
